// [isr_pkg.sv]
// constants and types of the identification and serial register bank
package isr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] ISR_IDX_SENSOR_ELEMENT_IDENTITY = 8'h01;
  localparam logic [7:0] ISR_IDX_PART_IDENTITY_HIGH = 8'h02;
  localparam logic [7:0] ISR_IDX_PART_IDENTITY_LOW_REVISION = 8'h03;
  localparam logic [7:0] ISR_IDX_FACTORY_SERIAL_BYTE_0 = 8'h04;
  localparam logic [7:0] ISR_IDX_FACTORY_SERIAL_BYTE_1 = 8'h05;
  localparam logic [7:0] ISR_IDX_FACTORY_SERIAL_BYTE_2 = 8'h06;
  localparam logic [7:0] ISR_IDX_FACTORY_SERIAL_BYTE_3 = 8'h07;
  localparam logic [7:0] ISR_IDX_FACTORY_SERIAL_BYTE_4 = 8'h08;
  localparam int ISR_ADDR_SHIFT = 2;
  // reset values of the serial bytes
  localparam logic [7:0] ISR_SERIAL_RESET = 8'h00;
  // field widths
  localparam int ISR_PART_W = 12;
  localparam int ISR_REV_W = 4;
  localparam int ISR_FAC_W = 3;
  localparam int ISR_CHAR_W = 6;
  localparam int ISR_LOT_W = 10;
  localparam int ISR_WAFER_W = 5;
  // field limits
  localparam logic [2:0] ISR_FAC_MAX = 3'h1;
  localparam logic [5:0] ISR_CHAR_MAX = 6'h23;
  localparam logic [5:0] ISR_CHAR_FALLBACK = 6'h00;
  localparam logic [9:0] ISR_LOT_MAX = 10'h3E7;
  localparam logic [4:0] ISR_WAFER_MIN = 5'h01;
  // field positions within the serial bytes
  localparam int ISR_S0_FAC_LSB = 5;
  localparam int ISR_S1_C1_BIT = 7;
  localparam int ISR_S1_C2_LSB = 1;
  localparam int ISR_S1_C3_BIT = 0;
  localparam int ISR_S2_C3_LSB = 3;
  localparam int ISR_S3_LOT_LSB = 4;
  localparam int ISR_S4_WAFER_BIT = 7;
  // apb read answer
  typedef struct packed {
    logic [31:0] data;
    logic err;
  } isr_answer_t;
  // complete state of the bank
  typedef struct packed {
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic loaded;
    logic [7:0] sn0;
    logic [7:0] sn1;
    logic [7:0] sn2;
    logic [7:0] sn3;
    logic [7:0] sn4;
  } isr_state_t;
endpackage

// [isr_regs.sv]
// identification and factory serial register bank on apb
//
// The APB interface to the registers was chosen for this implementation.
module isr_regs
  import isr_pkg::*;
#(
  parameter int ADDR_W = 12,
  // identity values: arbitrary
  parameter logic [7:0] SENSOR_ELEMENT_ID = 8'h5A,
  parameter logic [ISR_PART_W-1:0] PART_IDENTIFIER = 12'h123,
  parameter logic [ISR_REV_W-1:0] REVISION = 4'h1,
  // factory serial contents
  parameter logic [ISR_FAC_W-1:0] FACILITY = 3'h0,
  parameter logic [ISR_CHAR_W-1:0] CHAR_FIRST = 6'h0A,
  parameter logic [ISR_CHAR_W-1:0] CHAR_SECOND = 6'h01,
  parameter logic [ISR_CHAR_W-1:0] CHAR_THIRD = 6'h23,
  parameter logic [ISR_LOT_W-1:0] LOT = 10'h07B,
  parameter logic [ISR_WAFER_W-1:0] WAFER = 5'h11
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  isr_state_t state;
  isr_state_t next_state;

  // replace a character code above the used range by the fallback code
  function automatic logic [5:0] isr_char(input logic [5:0] c);
    isr_char = (c > ISR_CHAR_MAX) ? ISR_CHAR_FALLBACK : c;
  endfunction

  // index of a word address, all ones when misaligned
  function automatic logic [7:0] isr_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a >> ISR_ADDR_SHIFT;
    if (a[1:0] != 2'b00 || w > ADDR_W'(8'hFF))
      isr_index = 8'hFF;
    else
      isr_index = w[7:0];
  endfunction

  // sanitised field values
  logic [2:0] fac_v;
  logic [5:0] c1_v;
  logic [5:0] c2_v;
  logic [5:0] c3_v;
  logic [9:0] lot_v;
  logic [4:0] wafer_v;
  assign fac_v = (FACILITY > ISR_FAC_MAX) ? 3'h0 : FACILITY;
  assign c1_v = isr_char(CHAR_FIRST);
  assign c2_v = isr_char(CHAR_SECOND);
  assign c3_v = isr_char(CHAR_THIRD);
  assign lot_v = (LOT > ISR_LOT_MAX) ? ISR_LOT_MAX : LOT;
  assign wafer_v = (WAFER < ISR_WAFER_MIN) ? ISR_WAFER_MIN : WAFER;

  // read multiplexer
  function automatic isr_answer_t isr_read(input logic [7:0] idx,
                                           input isr_state_t s);
    isr_answer_t r;
    r.data = 32'h0000_0000;
    r.err = 1'b0;
    case (idx)
      ISR_IDX_SENSOR_ELEMENT_IDENTITY: r.data[7:0] = SENSOR_ELEMENT_ID;
      ISR_IDX_PART_IDENTITY_HIGH: r.data[7:0] = PART_IDENTIFIER[11:4];
      ISR_IDX_PART_IDENTITY_LOW_REVISION:
        r.data[7:0] = {PART_IDENTIFIER[3:0], REVISION};
      ISR_IDX_FACTORY_SERIAL_BYTE_0: r.data[7:0] = s.sn0;
      ISR_IDX_FACTORY_SERIAL_BYTE_1: r.data[7:0] = s.sn1;
      ISR_IDX_FACTORY_SERIAL_BYTE_2: r.data[7:0] = s.sn2;
      ISR_IDX_FACTORY_SERIAL_BYTE_3: r.data[7:0] = s.sn3;
      ISR_IDX_FACTORY_SERIAL_BYTE_4: r.data[7:0] = s.sn4;
      default: r.err = 1'b1;
    endcase
    isr_read = r;
  endfunction

  logic [7:0] idx;
  logic access;
  isr_answer_t answer;
  assign idx = isr_index(paddr);
  assign access = psel && penable && !state.ready;
  assign answer = isr_read(idx, state);

  always_comb
  begin
    next_state = state;
    // one-time factory load after reset
    if (!state.loaded)
    begin
      next_state.loaded = 1'b1;
      next_state.sn0 = {fac_v, c1_v[5:1]};
      next_state.sn1 = {c1_v[0], c2_v, c3_v[5]};
      next_state.sn2 = {c3_v[4:0], lot_v[6:4]};
      next_state.sn3 = {lot_v[3:0], wafer_v[4:1]};
      next_state.sn4 = {wafer_v[0], 7'h00};
    end
    // one wait state, then the answer; writes change nothing
    if (state.ready)
    begin
      next_state.ready = 1'b0;
      next_state.err = 1'b0;
    end
    else if (access)
    begin
      next_state.ready = 1'b1;
      next_state.err = answer.err;
      next_state.rdata = pwrite ? 32'h0000_0000 : answer.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '{ready: 1'b0, err: 1'b0, rdata: 32'h0000_0000,
                 loaded: 1'b0, sn0: ISR_SERIAL_RESET,
                 sn1: ISR_SERIAL_RESET, sn2: ISR_SERIAL_RESET,
                 sn3: ISR_SERIAL_RESET, sn4: ISR_SERIAL_RESET};
    end
    else if (pclken)
    begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.err;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;

  sensor_id_read_a: assert property (
    rd_done && idx == ISR_IDX_SENSOR_ELEMENT_IDENTITY
    |-> prdata == {24'h000000, SENSOR_ELEMENT_ID} && !pslverr)
    else $error("sensor identity read wrong");

  part_identifier_read_a: assert property (
    rd_done && idx == ISR_IDX_PART_IDENTITY_HIGH
    |-> prdata[7:0] == PART_IDENTIFIER[11:4] && prdata[31:8] == 24'h000000)
    else $error("part identity high read wrong");

  part_rev_read_a: assert property (
    rd_done && idx == ISR_IDX_PART_IDENTITY_LOW_REVISION
    |-> prdata[7:0] == {PART_IDENTIFIER[3:0], REVISION})
    else $error("part low and revision read wrong");

  facility_code_a: assert property (
    state.loaded |-> state.sn0[7:5] <= ISR_FAC_MAX)
    else $error("facility code out of range");

  char_range_a: assert property (
    state.loaded |-> {state.sn0[4:0], state.sn1[7]} <= ISR_CHAR_MAX
      && state.sn1[6:1] <= ISR_CHAR_MAX
      && {state.sn1[0], state.sn2[7:3]} <= ISR_CHAR_MAX)
    else $error("serial character code unused value");

  char_layout_a: assert property (
    state.loaded |-> {state.sn0[4:0], state.sn1[7]} == c1_v
      && state.sn1[6:1] == c2_v
      && {state.sn1[0], state.sn2[7:3]} == c3_v)
    else $error("serial character placement wrong");

  lot_layout_a: assert property (
    state.loaded |-> {state.sn2[2:0], state.sn3[7:4]} == lot_v[6:0])
    else $error("lot number placement wrong");

  wafer_field_a: assert property (
    state.loaded |-> {state.sn3[3:0], state.sn4[7]} == wafer_v
      && {state.sn3[3:0], state.sn4[7]} != 5'h00
      && state.sn4[6:0] == 7'h00)
    else $error("wafer index wrong or zero");

  serial_read_a: assert property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_0
    |-> prdata[7:0] == $past(state.sn0) && !pslverr)
    else $error("serial byte 0 read wrong");

  // factory load and its permanence
  load_once_a: assert property (
    !state.loaded && pclken |=> state.loaded)
    else $error("serial contents not loaded");

  serial_frozen_a: assert property (
    state.loaded |=> state.loaded && $stable(state.sn0) && $stable(state.sn1)
      && $stable(state.sn2) && $stable(state.sn3) && $stable(state.sn4))
    else $error("serial contents changed after load");

  write_ignored_a: assert property (
    state.loaded && psel && penable && pwrite
    |=> $stable(state.sn0) && $stable(state.sn3) && $stable(state.sn4))
    else $error("write altered serial contents");

  answer_timing_a: assert property (
    psel && penable && !pready && pclken
    |=> pready ##1 (!pready || !$past(pclken)))
    else $error("apb answer not after one wait state");

  unmapped_err_a: assert property (
    psel && penable && !pready && pclken && idx == 8'h00
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  // serial bytes read back as stored
  byte1_read_a: assert property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_1
    |-> prdata[7:0] == $past(state.sn1) && !pslverr)
    else $error("serial byte 1 read wrong");

  byte2_read_a: assert property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_2
    |-> prdata[7:0] == $past(state.sn2) && !pslverr)
    else $error("serial byte 2 read wrong");

  byte3_read_a: assert property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_3
    |-> prdata[7:0] == $past(state.sn3) && !pslverr)
    else $error("serial byte 3 read wrong");

  byte4_read_a: assert property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_4
    |-> prdata[7:0] == $past(state.sn4) && !pslverr)
    else $error("serial byte 4 read wrong");

  serial_reset_a: assert property (
    !state.loaded |-> state.sn0 == ISR_SERIAL_RESET
      && state.sn1 == ISR_SERIAL_RESET && state.sn2 == ISR_SERIAL_RESET
      && state.sn3 == ISR_SERIAL_RESET && state.sn4 == ISR_SERIAL_RESET)
    else $error("serial bytes not at reset value before load");

  revision_read_a: assert property (
    psel && penable && !pready && pclken && !pwrite
      && idx == ISR_IDX_PART_IDENTITY_LOW_REVISION
    |=> prdata[3:0] == REVISION)
    else $error("revision field read wrong");

  // error and write answers
  write_answer_a: assert property (
    psel && penable && pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("write answer carries data");

  misaligned_err_a: assert property (
    psel && penable && !pready && pclken && paddr[1:0] != 2'b00
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not flagged");

  mapped_ok_a: assert property (
    psel && penable && !pready && pclken && paddr[1:0] == 2'b00
      && idx >= ISR_IDX_SENSOR_ELEMENT_IDENTITY
      && idx <= ISR_IDX_FACTORY_SERIAL_BYTE_4
    |=> !pslverr)
    else $error("mapped access flagged as error");

  // clock enable and answer shape
  enable_freeze_a: assert property (
    !pclken |=> $stable(pready) && $stable(prdata) && $stable(pslverr))
    else $error("outputs moved while clock enable low");

  ready_pulse_a: assert property (
    pready && pclken |=> !pready)
    else $error("pready held beyond one cycle");

  upper_zero_a: assert property (
    rd_done |-> prdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  read_sensor_c: cover property (
    rd_done && idx == ISR_IDX_SENSOR_ELEMENT_IDENTITY);
  read_serial_c: cover property (
    rd_done && idx == ISR_IDX_FACTORY_SERIAL_BYTE_4);
  write_ignore_c: cover property (
    psel && penable && pready && pwrite && !pslverr);
  unmapped_c: cover property (psel && penable && pready && pslverr);
  stretched_c: cover property (psel && penable && !pclken);

endmodule

// [identity_serial_regs_tb.sv]
// self-checking testbench of the identification and serial bank
module identity_serial_regs_tb
  import isr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  // identity values: arbitrary
  localparam logic [7:0] SEN = 8'h5A;
  localparam logic [11:0] PID = 12'h123;
  localparam logic [3:0] REV = 4'h1;
  // facility, first character, lot and wafer at the top of their legal ranges
  localparam logic [2:0] FAC = 3'h1;
  localparam logic [5:0] C1 = 6'h23;
  localparam logic [5:0] C2 = 6'h0A;
  localparam logic [5:0] C3 = 6'h21;
  localparam logic [9:0] LOT = 10'h3E7;
  localparam logic [4:0] WAF = 5'h1F;
  // bytes of indices 1 to 8, first index in the top byte
  localparam logic [63:0] EXPV = {SEN, PID, REV, FAC, C1[5:1], C1[0], C2,
    C3[5], C3[4:0], LOT[6:4], LOT[3:0], WAF[4:1], WAF[0], 7'h00};
  logic pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  isr_regs #(.ADDR_W(12), .SENSOR_ELEMENT_ID(SEN), .PART_IDENTIFIER(PID),
    .REVISION(REV), .FACILITY(FAC), .CHAR_FIRST(C1), .CHAR_SECOND(C2),
    .CHAR_THIRD(C3), .LOT(LOT), .WAFER(WAF)) u_dut (.pclk(pclk),
    .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task stop_test;
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask
  // one apb transfer; hold freezes the clock enable in the access phase
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input int hold, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (hold > 0)
      pclken <= 1'b0;
    repeat (hold)
    begin
      @(posedge pclk);
      check("pready frozen", {31'h0, pready}, 32'h0);
    end
    pclken <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset_idle;
    check("prdata in reset", prdata, 32'h0);
    check("pready in reset", {31'h0, pready}, 32'h0);
    check("pslverr in reset", {31'h0, pslverr}, 32'h0);
  endtask
  task t_read_all;
    logic [31:0] rd;
    logic er;
    for (int i = 1; i <= 8; i++)
    begin
      apb(12'(i << ISR_ADDR_SHIFT), 1'b0, 32'h0, 0, rd, er);
      check("register byte", rd,
      {24'h0, EXPV[71-8*i -: 8]});
      check("read pslverr", {31'h0, er}, 32'h0);
    end
  endtask
  task t_write_ignored;
    logic [31:0] rd;
    logic er;
    for (int i = 1; i <= 8; i++)
    begin
      apb(12'(i << ISR_ADDR_SHIFT), 1'b1, 32'hFFFFFFFF, 0, rd, er);
      check("write pslverr", {31'h0, er}, 32'h0);
      check("write prdata", rd, 32'h0);
    end
    t_read_all();
  endtask
  task t_unmapped;
    logic [31:0] rd;
    logic er;
    logic [11:0] bad [4];
    bad = '{12'h000, 12'h024, 12'h005, 12'hFFC};
    foreach (bad[k])
    begin
      apb(bad[k], 1'b0, 32'h0, 0, rd, er);
      check("unmapped pslverr", {31'h0, er}, 32'h1);
      check("unmapped prdata", rd, 32'h0);
    end
  endtask
  task t_stretch;
    logic [31:0] rd;
    logic er;
    apb(12'h010, 1'b0, 32'h0, 3, rd, er);
    check("stretched read", rd, {24'h0, EXPV[39:32]});
  endtask
  task t_mid_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    t_reset_idle();
    presetn <= 1'b1;
    @(posedge pclk);
    t_read_all();
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    presetn = 1'b0;
    pclken = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (2) @(posedge pclk);
    t_reset_idle();
    presetn <= 1'b1;
    @(posedge pclk);
    t_read_all();
    t_write_ignored();
    t_unmapped();
    t_stretch();
    t_mid_reset();
    stop_test();
  end
endmodule
